/* File: pdp_pin_model.sv */
// Pin-side model: external sources, pull-ups and resolution of each pin level
`timescale 1ns/100ps
module pdp_pin_model
(
	input wire logic clk_in,
	input wire logic [23:0] drive_in,
	input wire logic [23:0] oe_in,
	input wire logic [23:0] pullup_in,
	input wire logic [23:0] ext_en_in,
	input wire logic [23:0] ext_val_in,
	output logic [23:0] level_out
);
	// ==============================================
	// Floating level
	logic [23:0] float_reg = 24'h5A3C96;

	// Undriven pins 23:1 wander, each flipping in a cycle where the bit below it is 0; bit 0 stays low
	always @(posedge clk_in)
	begin
		float_reg <= ~float_reg ^ {float_reg[22:0], 1'h1};
	end

	// ==============================================
	// Resolution
	// Chip driver wins, then an external source, then the pull-up
	assign level_out = (oe_in & drive_in)
		| (~oe_in & ext_en_in & ext_val_in)
		| (~oe_in & ~ext_en_in & (pullup_in | float_reg));
endmodule

/* File: pdp_pkg.sv */
// Shared constants and carrier types for the port direction and pull-up block
package pdp_pkg;

	// ==============================================
	// Register map
	localparam int unsigned PORT_COUNT = 4;
	localparam logic [15:0] DIRECTION_ADDR [0:3] = '{16'hFF20, 16'hFF21, 16'hFF22, 16'hFF23};
	// Output latch addresses of ports 0 to 3
	localparam logic [15:0] LATCH_ADDR [0:3] = '{16'hFF00, 16'hFF01, 16'hFF02, 16'hFF03};
	localparam logic [15:0] PORT2_PULLUP_SELECT_ADDR = 16'hFF32;
	localparam logic [15:0] PORT_GROUP_PULLUP_SELECT_ADDR = 16'hFFF7;

	// ==============================================
	// Reset values and field layouts
	localparam logic [7:0] DIRECTION_RESET = 8'hFF;
	localparam logic [7:0] LATCH_RESET = 8'h00;
	localparam logic [7:0] PULLUP_RESET = 8'h00;
	localparam logic [7:0] READ_UNMAPPED = 8'h00;
	// Implemented pins per port: 8, 6, 8 and 2
	localparam logic [7:0] PORT_MASK [0:3] = '{8'hFF, 8'h3F, 8'hFF, 8'h03};
	// Only bits 0, 1 and 3 of the group pull-up register exist
	localparam logic [7:0] GROUP_PULLUP_MASK = 8'h0B;
	localparam int unsigned GROUP_PULLUP_PORT0_BIT = 0;
	localparam int unsigned GROUP_PULLUP_PORT1_BIT = 1;
	localparam int unsigned GROUP_PULLUP_PORT3_BIT = 3;
	localparam int unsigned IRQ_PORT = 2;
	localparam int unsigned EXT_IRQ_A_PIN = 4;
	localparam int unsigned EXT_IRQ_B_PIN = 5;
	localparam int unsigned EXT_IRQ_C_PIN = 6;
	localparam int unsigned TIMER8_OUTPUT_PIN = 7;
	localparam int unsigned TIMER16_OUTPUT_PIN = 0;
	localparam int unsigned BUZZER_OUTPUT_PIN = 1;
	// Alternate output select bit order
	localparam int unsigned ALT_TIMER8 = 0;
	localparam int unsigned ALT_TIMER16 = 1;
	localparam int unsigned ALT_BUZZER = 2;

	// ==============================================
	// Carrier types
	typedef struct packed {
		logic valid;
		logic write;
		logic bit_op;
		logic [2:0] bit_sel;
		logic bit_val;
		logic [15:0] addr;
		logic [7:0] wdata;
	} pdp_cpu_req_t;

	typedef struct packed {
		logic [1:0] p3;
		logic [7:0] p2;
		logic [5:0] p1;
		logic [7:0] p0;
	} pdp_pin_group_t;

endpackage

/* File: pdp_port_bank.sv */
// One port group: direction, output latch, read selector and pin drivers
`timescale 1ns/100ps
module pdp_port_bank
#(
	parameter logic [7:0] PIN_MASK = 8'hFF
)
(
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic dir_wr_in,
	input wire logic [7:0] dir_wdata_in,
	input wire logic lat_wr_in,
	input wire logic [7:0] lat_wdata_in,
	input wire logic [7:0] pin_in,
	input wire logic [7:0] alt_en_in,
	input wire logic [7:0] alt_data_in,
	output logic [7:0] dir_out,
	output logic [7:0] latch_out,
	output logic [7:0] read_out,
	output logic [7:0] drive_out,
	output logic [7:0] oe_out,
	output logic [7:0] change_out
);

	// ==============================================
	// Storage
	logic [7:0] dir_reg;
	logic [7:0] latch_reg;
	logic [7:0] drive_reg;
	logic [7:0] oe_reg;
	logic [7:0] drive_next;
	logic [7:0] oe_next;

	// Direction bits, all inputs out of reset
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			dir_reg <= pdp_pkg::DIRECTION_RESET;
		else if (dir_wr_in)
			dir_reg <= dir_wdata_in & PIN_MASK;
	end

	// Latch is written in either mode and held until the next write
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			latch_reg <= pdp_pkg::LATCH_RESET;
		else if (lat_wr_in)
			latch_reg <= lat_wdata_in & PIN_MASK;
	end

	// Alternate output is ORed in, which is why its latch must hold 0
	assign drive_next = (latch_reg | (alt_en_in & alt_data_in)) & PIN_MASK;
	assign oe_next = ~dir_reg & PIN_MASK;

	// Registered pin drivers
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			drive_reg <= 8'h00;
			oe_reg <= 8'h00;
		end
		else
		begin
			drive_reg <= drive_next;
			oe_reg <= oe_next;
		end
	end

	// Readback: unbuilt direction bits read as 1, latch read never alters it
	assign dir_out = dir_reg | ~PIN_MASK;
	assign latch_out = latch_reg;
	assign read_out = ((dir_reg & pin_in) | (~dir_reg & latch_reg)) & PIN_MASK;
	assign drive_out = drive_reg;
	assign oe_out = oe_reg;
	// Level change on a pin that is driven both before and after
	assign change_out = (drive_next ^ drive_reg) & oe_next & oe_reg;

endmodule

/* File: pdp_port_control.sv */
// Top of the port block: CPU register access, pull-up control, pin outputs
//
// How it works
// - Direction bit 0 drives the pin as output, 1 makes it an input.
// - Reset loads every direction register with all ones.
// - A driven port-2 level change raises the matching external interrupt request.
// - Group pull-up bits 0, 1, 3 enable pull-ups on ports 0, 1, 3.
// - Group pull-ups reach input-mode bits only, never output-mode bits.
// - No pull-up on port 0, 1, 3 pins serving alternate outputs.
// - Reset clears both pull-up select registers.
// - Each port-2 pull-up bit acts on its pin regardless of direction.
// - Direction and pull-up registers accept single-bit and byte writes.
// - Output mode: write updates the latch and drives it onto the pin.
// - Input mode: write updates the latch; pin level stays undriven.
// - Reading an output-mode bit returns the latch, unchanged.
// - Reading an input-mode bit returns the pin level, latch unchanged.
// - Single-bit port operations run as whole-byte accesses.
// - Arithmetic on output bits stores result in latch and drives it.
// - Arithmetic on input bits may spoil the latch; pin stays unchanged.
// - Ports carry 8, 6, 8 and 2 pins, each with a latch.
`timescale 1ns/100ps
module pdp_port_control
(
	input wire logic sys_clk_in,
	input wire logic reset_n_in,
	input wire pdp_pkg::pdp_cpu_req_t cpu_req_in,
	input wire pdp_pkg::pdp_pin_group_t pin_in,
	input wire logic [2:0] alt_out_en_in,
	input wire logic [2:0] alt_out_data_in,
	output pdp_pkg::pdp_pin_group_t pin_out_out,
	output pdp_pkg::pdp_pin_group_t pin_oe_out,
	output pdp_pkg::pdp_pin_group_t pullup_out,
	output logic [2:0] ext_irq_req_out,
	output logic [7:0] rdata_out,
	output logic rd_valid_out
);

	// ==============================================
	// Reset release
	logic rst_meta_reg;
	logic rst_sync_reg;
	logic rst_n;

	// Two flops so release never lands near a clock edge
	always_ff @(posedge sys_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end
		else
		begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end
	assign rst_n = rst_sync_reg;

	// ==============================================
	// Decode
	logic [7:0] pin_byte [0:3];
	logic [7:0] alt_en_byte [0:3];
	logic [7:0] alt_data_byte [0:3];
	logic [7:0] dir_rd [0:3];
	logic [7:0] latch_q [0:3];
	logic [7:0] port_rd [0:3];
	logic [7:0] drive_q [0:3];
	logic [7:0] oe_q [0:3];
	logic [7:0] change [0:3];
	logic [3:0] dir_wr;
	logic [3:0] lat_wr;
	logic [7:0] dir_wdata [0:3];
	logic [7:0] lat_wdata [0:3];
	logic req_wr;
	logic req_rd;
	logic p2_pu_wr;
	logic grp_pu_wr;
	logic [7:0] p2_pu_reg;
	logic [7:0] grp_pu_reg;
	logic [7:0] rdata_next;
	logic [7:0] pullup_next [0:3];
	logic [7:0] pullup_reg [0:3];

	// Byte result: a bit operation replaces one bit of the supplied base
	function automatic logic [7:0] merge_byte(input logic [7:0] base,
		input pdp_pkg::pdp_cpu_req_t req);
		logic [7:0] value;
		value = base;
		if (req.bit_op)
			value[req.bit_sel] = req.bit_val;
		else
			value = req.wdata;
		return value;
	endfunction

	assign req_wr = cpu_req_in.valid && cpu_req_in.write;
	assign req_rd = cpu_req_in.valid && !cpu_req_in.write;
	assign p2_pu_wr = req_wr && (cpu_req_in.addr == pdp_pkg::PORT2_PULLUP_SELECT_ADDR);
	assign grp_pu_wr = req_wr && (cpu_req_in.addr == pdp_pkg::PORT_GROUP_PULLUP_SELECT_ADDR);

	// Pin side byte lanes, unbuilt pins tied low
	assign pin_byte[0] = pin_in.p0;
	assign pin_byte[1] = {2'h0, pin_in.p1};
	assign pin_byte[2] = pin_in.p2;
	assign pin_byte[3] = {6'h00, pin_in.p3};
	assign alt_en_byte[0] = 8'h00;
	assign alt_en_byte[1] = 8'h00;
	assign alt_en_byte[2] = {alt_out_en_in[pdp_pkg::ALT_TIMER8], 7'h00};
	assign alt_en_byte[3] = {6'h00, alt_out_en_in[pdp_pkg::ALT_BUZZER],
		alt_out_en_in[pdp_pkg::ALT_TIMER16]};
	assign alt_data_byte[0] = 8'h00;
	assign alt_data_byte[1] = 8'h00;
	assign alt_data_byte[2] = {alt_out_data_in[pdp_pkg::ALT_TIMER8], 7'h00};
	assign alt_data_byte[3] = {6'h00, alt_out_data_in[pdp_pkg::ALT_BUZZER],
		alt_out_data_in[pdp_pkg::ALT_TIMER16]};

	// ==============================================
	// Port banks
	genvar g;
	generate
		for (g = 0; g < pdp_pkg::PORT_COUNT; g++)
		begin : gen_port
			assign dir_wr[g] = req_wr && (cpu_req_in.addr == pdp_pkg::DIRECTION_ADDR[g]);
			assign lat_wr[g] = req_wr && (cpu_req_in.addr == pdp_pkg::LATCH_ADDR[g]);
			assign dir_wdata[g] = merge_byte(dir_rd[g], cpu_req_in);
			// Other input bits pick up the pin level, so their latch is not kept
			assign lat_wdata[g] = merge_byte(port_rd[g], cpu_req_in);
			pdp_port_bank #(
				.PIN_MASK(pdp_pkg::PORT_MASK[g])
			) u_bank (
				.clk_in(sys_clk_in),
				.rst_n_in(rst_n),
				.dir_wr_in(dir_wr[g]),
				.dir_wdata_in(dir_wdata[g]),
				.lat_wr_in(lat_wr[g]),
				.lat_wdata_in(lat_wdata[g]),
				.pin_in(pin_byte[g]),
				.alt_en_in(alt_en_byte[g]),
				.alt_data_in(alt_data_byte[g]),
				.dir_out(dir_rd[g]),
				.latch_out(latch_q[g]),
				.read_out(port_rd[g]),
				.drive_out(drive_q[g]),
				.oe_out(oe_q[g]),
				.change_out(change[g])
			);
		end
	endgenerate

	// ==============================================
	// Pull-up select registers
	always_ff @(posedge sys_clk_in or negedge rst_n)
	begin
		if (!rst_n)
			p2_pu_reg <= pdp_pkg::PULLUP_RESET;
		else if (p2_pu_wr)
			p2_pu_reg <= merge_byte(p2_pu_reg, cpu_req_in);
	end

	// Unbuilt group bits are not stored and read back as zero
	always_ff @(posedge sys_clk_in or negedge rst_n)
	begin
		if (!rst_n)
			grp_pu_reg <= pdp_pkg::PULLUP_RESET;
		else if (grp_pu_wr)
			grp_pu_reg <= merge_byte(grp_pu_reg, cpu_req_in)
				& pdp_pkg::GROUP_PULLUP_MASK;
	end

	// Group pull-ups only on input bits; alternate outputs on port 3 excluded
	always_comb
	begin
		pullup_next[0] = {8{grp_pu_reg[pdp_pkg::GROUP_PULLUP_PORT0_BIT]}} & dir_rd[0]
			& pdp_pkg::PORT_MASK[0];
		pullup_next[1] = {8{grp_pu_reg[pdp_pkg::GROUP_PULLUP_PORT1_BIT]}} & dir_rd[1]
			& pdp_pkg::PORT_MASK[1];
		pullup_next[2] = p2_pu_reg;
		pullup_next[3] = {8{grp_pu_reg[pdp_pkg::GROUP_PULLUP_PORT3_BIT]}} & dir_rd[3]
			& ~alt_en_byte[3] & pdp_pkg::PORT_MASK[3];
	end

	// Registered pull-up controls
	always_ff @(posedge sys_clk_in or negedge rst_n)
	begin
		if (!rst_n)
			pullup_reg <= '{default: pdp_pkg::PULLUP_RESET};
		else
			pullup_reg <= pullup_next;
	end

	// ==============================================
	// Read path
	always_comb
	begin
		rdata_next = pdp_pkg::READ_UNMAPPED;
		for (int m = 0; m < pdp_pkg::PORT_COUNT; m++)
		begin
			if (cpu_req_in.addr == pdp_pkg::DIRECTION_ADDR[m])
				rdata_next = dir_rd[m];
			if (cpu_req_in.addr == pdp_pkg::LATCH_ADDR[m])
				rdata_next = port_rd[m];
		end
		if (cpu_req_in.addr == pdp_pkg::PORT2_PULLUP_SELECT_ADDR)
			rdata_next = p2_pu_reg;
		if (cpu_req_in.addr == pdp_pkg::PORT_GROUP_PULLUP_SELECT_ADDR)
			rdata_next = grp_pu_reg;
	end

	// Read answer one cycle after the request
	always_ff @(posedge sys_clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rdata_out <= 8'h00;
			rd_valid_out <= 1'b0;
		end
		else
		begin
			rd_valid_out <= req_rd;
			if (req_rd)
				rdata_out <= rdata_next;
		end
	end

	// ==============================================
	// External interrupt requests from port 2; the CPU mask must guard them
	always_ff @(posedge sys_clk_in or negedge rst_n)
	begin
		if (!rst_n)
			ext_irq_req_out <= 3'h0;
		else
			ext_irq_req_out <= {change[pdp_pkg::IRQ_PORT][pdp_pkg::EXT_IRQ_C_PIN],
				change[pdp_pkg::IRQ_PORT][pdp_pkg::EXT_IRQ_B_PIN],
				change[pdp_pkg::IRQ_PORT][pdp_pkg::EXT_IRQ_A_PIN]};
	end

	// Pin outputs straight from the bank flops, pull-ups from the pull-up flops
	assign pin_out_out = {drive_q[3][1:0], drive_q[2], drive_q[1][5:0], drive_q[0]};
	assign pin_oe_out = {oe_q[3][1:0], oe_q[2], oe_q[1][5:0], oe_q[0]};
	assign pullup_out = {pullup_reg[3][1:0], pullup_reg[2], pullup_reg[1][5:0], pullup_reg[0]};

	// ==============================================
	// Assertions
	sequence s_latch_write_input;
		lat_wr[0] && !cpu_req_in.bit_op && (dir_rd[0] == 8'hFF);
	endsequence

	sequence s_latch_held_undriven;
		(latch_q[0] == $past(cpu_req_in.wdata)) ##1 (pin_oe_out.p0 == 8'h00);
	endsequence

	a_output_enable_dir: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
		pin_oe_out.p2 == ~$past(dir_rd[2]))
		else $error("pin enable does not follow direction");

	a_dir_reset_ones: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
		(rst_n && !$past(rst_n)) |-> (dir_rd[0] == 8'hFF) && (dir_rd[2] == 8'hFF))
		else $error("direction not all ones after reset");

	a_irq_level_change: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
		($changed(pin_out_out.p2[4]) && pin_oe_out.p2[4] && $past(pin_oe_out.p2[4]))
		== ext_irq_req_out[0])
		else $error("interrupt request does not match driven level change");

	a_group_pullup_input: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
		pullup_out.p0[0] |-> $past(dir_rd[0][0]) && $past(grp_pu_reg[0]))
		else $error("group pull-up on output bit");

	a_alt_no_pullup: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
		$past(alt_out_en_in[pdp_pkg::ALT_TIMER16]) |-> !pullup_out.p3[0])
		else $error("pull-up on alternate output pin");

	a_pullup_reset_zero: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
		(rst_n && !$past(rst_n)) |-> (p2_pu_reg == 8'h00) && (grp_pu_reg == 8'h00))
		else $error("pull-up select not cleared by reset");

	a_port2_pullup_free: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
		pullup_out.p2 == $past(p2_pu_reg))
		else $error("port 2 pull-up ignores its select bit");

	a_bit_write_one: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
		(dir_wr[0] && cpu_req_in.bit_op) |=>
		(dir_rd[0][$past(cpu_req_in.bit_sel)] == $past(cpu_req_in.bit_val))
		&& (((dir_rd[0] ^ $past(dir_rd[0])) & ~(8'h01 << $past(cpu_req_in.bit_sel))) == 8'h00))
		else $error("bit write touched other direction bits");

	a_input_latch_hold: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
		s_latch_write_input |=> s_latch_held_undriven)
		else $error("input mode write drove the pin or lost the latch");

	a_read_selects: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
		(req_rd && (cpu_req_in.addr == pdp_pkg::LATCH_ADDR[0])) |=> rd_valid_out
		&& (rdata_out == (($past(dir_rd[0]) & $past(pin_in.p0))
		| (~$past(dir_rd[0]) & $past(latch_q[0])))))
		else $error("port read returned wrong source");

endmodule

/* File: port_direction_pullup_control_tb.sv */
// Self-checking bench for the port direction and pull-up block
`timescale 1ns/100ps
module port_direction_pullup_control_tb;
	logic sys_clk_in = 1'h0;
	logic reset_n_in = 1'h0;
	pdp_pkg::pdp_cpu_req_t req = '0;
	logic [2:0] alt_en = 3'h0;
	logic [2:0] alt_dat = 3'h0;
	logic [23:0] ext_en = 24'h000000;
	logic [23:0] ext_val = 24'h000000;
	logic [23:0] pin_lvl, pin_drv, pin_oe, pin_pu;
	logic [2:0] irq;
	logic [7:0] rdata;
	logic rd_valid;
	int err_total = 0;
	int n_tests = 0;
	int cyc = 0;
	int seed = 32'h55ED2B39;

	// ==============================================
	// Design and pin side
	pdp_port_control i_pdp_port_control (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
		.cpu_req_in(req), .pin_in(pin_lvl), .alt_out_en_in(alt_en), .alt_out_data_in(alt_dat),
		.pin_out_out(pin_drv), .pin_oe_out(pin_oe), .pullup_out(pin_pu),
		.ext_irq_req_out(irq), .rdata_out(rdata), .rd_valid_out(rd_valid));
	pdp_pin_model i_pdp_pin_model (.clk_in(sys_clk_in), .drive_in(pin_drv), .oe_in(pin_oe),
		.pullup_in(pin_pu), .ext_en_in(ext_en), .ext_val_in(ext_val), .level_out(pin_lvl));

	always #10 sys_clk_in = ~sys_clk_in;

	// ==============================================
	// Helpers
	function automatic logic [7:0] sel(logic [23:0] g, int p);
		case (p)
			0: return g[7:0];
			1: return {2'h0, g[13:8]};
			2: return g[21:14];
			default: return {6'h00, g[23:22]};
		endcase
	endfunction

	task automatic chk(logic [23:0] got, logic [23:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			err_total++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One request, held across exactly one sampling edge
	task automatic acc(logic w, logic b, logic [2:0] bs, logic bv, logic [15:0] a,
		logic [7:0] d);
		@(posedge sys_clk_in) #1;
		req = {1'h1, w, b, bs, bv, a, d};
		@(posedge sys_clk_in) #1;
		req.valid = 1'h0;
	endtask

	task automatic wr(logic [15:0] a, logic [7:0] d);
		acc(1'h1, 1'h0, 3'h0, 1'h0, a, d);
	endtask

	// Read data is valid only alongside the one-cycle valid pulse
	task automatic rchk(logic [15:0] a, logic [7:0] exp);
		acc(1'h0, 1'h0, 3'h0, 1'h0, a, 8'h00);
		chk(rd_valid === 1'h1 ? rdata : 8'hXX, exp);
	endtask

	task automatic settle();
		@(posedge sys_clk_in) #1;
	endtask

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Hang guard, well above the few hundred cycles the tests need
	always @(posedge sys_clk_in)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			err_total++;
			complete_run();
		end
	end

	// ==============================================
	// Main sequence
	initial
	begin
		logic [7:0] v, w, g, ex;
		logic [7:0] rs [0:3];
		int wid [0:3];
		wid = '{8, 6, 8, 2};
		repeat (3) @(posedge sys_clk_in);
		#1 reset_n_in = 1'h1;
		repeat (2) @(posedge sys_clk_in);
		for (int p = 0; p < 4; p++)
			rchk(pdp_pkg::DIRECTION_ADDR[p], 8'hFF);
		rchk(pdp_pkg::PORT2_PULLUP_SELECT_ADDR, 8'h00);
		rchk(pdp_pkg::PORT_GROUP_PULLUP_SELECT_ADDR, 8'h00);
		chk(pin_oe | pin_pu, 24'h000000);
		$display("reset values done");
		// Random register traffic; unbuilt direction bits read one
		for (int i = 0; i < 8; i++)
		begin
			v = $random(seed);
			wr(pdp_pkg::DIRECTION_ADDR[i % 4], v);
			rchk(pdp_pkg::DIRECTION_ADDR[i % 4], v | ~pdp_pkg::PORT_MASK[i % 4]);
		end
		v = 8'($random(seed)) & pdp_pkg::GROUP_PULLUP_MASK;
		wr(pdp_pkg::PORT_GROUP_PULLUP_SELECT_ADDR, v);
		rchk(pdp_pkg::PORT_GROUP_PULLUP_SELECT_ADDR, v & pdp_pkg::GROUP_PULLUP_MASK);
		wr(pdp_pkg::DIRECTION_ADDR[0], 8'hFF);
		acc(1'h1, 1'h1, 3'h5, 1'h0, pdp_pkg::DIRECTION_ADDR[0], 8'h00);
		rchk(pdp_pkg::DIRECTION_ADDR[0], 8'hDF);
		rchk(16'hFF10, pdp_pkg::READ_UNMAPPED);
		$display("register access done");
		// Output then input mode on every port, pins held by outside sources
		ext_en = 24'hFFFFFF;
		for (int p = 0; p < 4; p++)
		begin
			ext_val = $random(seed);
			v = $random(seed);
			w = $random(seed);
			wr(pdp_pkg::DIRECTION_ADDR[p], 8'h00);
			wr(pdp_pkg::LATCH_ADDR[p], v);
			settle();
			chk(sel(pin_oe, p), pdp_pkg::PORT_MASK[p]);
			chk(sel(pin_drv, p), v & pdp_pkg::PORT_MASK[p]);
			rchk(pdp_pkg::LATCH_ADDR[p], v & pdp_pkg::PORT_MASK[p]);
			wr(pdp_pkg::DIRECTION_ADDR[p], 8'hFF);
			wr(pdp_pkg::LATCH_ADDR[p], w);
			settle();
			chk(sel(pin_oe, p), 8'h00);
			rchk(pdp_pkg::LATCH_ADDR[p], sel(ext_val, p));
			wr(pdp_pkg::DIRECTION_ADDR[p], 8'h00);
			settle();
			chk(sel(pin_drv, p), w & pdp_pkg::PORT_MASK[p]);
		end
		$display("port modes done");
		// Pull-ups with random selects and directions, pins left floating
		ext_en = 24'h000000;
		for (int it = 0; it < 4; it++)
		begin
			g = $random(seed);
			wr(pdp_pkg::PORT_GROUP_PULLUP_SELECT_ADDR, g & pdp_pkg::GROUP_PULLUP_MASK);
			wr(pdp_pkg::PORT2_PULLUP_SELECT_ADDR, g);
			for (int p = 0; p < 4; p++)
			begin
				rs[p] = $random(seed);
				wr(pdp_pkg::DIRECTION_ADDR[p], rs[p]);
			end
			settle();
			for (int p = 0; p < 4; p++)
			begin
				ex = p == 2 ? g : (g[p] ? rs[p] : 8'h00);
				chk(sel(pin_pu, p), ex & pdp_pkg::PORT_MASK[p]);
			end
		end
		alt_en = 3'h6;
		wr(pdp_pkg::DIRECTION_ADDR[3], 8'hFF);
		wr(pdp_pkg::PORT_GROUP_PULLUP_SELECT_ADDR, 8'h0B);
		settle();
		chk(sel(pin_pu, 3), 8'h00);
		alt_en = 3'h0;
		$display("pull-ups done");
		// Driven level change on interrupt pins 4 and 6, then a repeat write
		// Interrupt mask is taken as set outside before port 2 drives
		wr(pdp_pkg::DIRECTION_ADDR[2], 8'h00);
		wr(pdp_pkg::LATCH_ADDR[2], 8'h00);
		settle();
		wr(pdp_pkg::LATCH_ADDR[2], 8'h50);
		settle();
		chk(irq, 3'h5);
		settle();
		chk(irq, 3'h0);
		wr(pdp_pkg::LATCH_ADDR[2], 8'h50);
		settle();
		chk(irq, 3'h0);
		// Timer output through a cleared latch and direction
		wr(pdp_pkg::LATCH_ADDR[2], 8'h00);
		alt_en = 3'h1;
		alt_dat = 3'h1;
		settle();
		settle();
		chk(sel(pin_drv, 2), 8'h80);
		alt_en = 3'h0;
		$display("interrupt and alternate output done");
		// Bit operations on ports mixing inputs and outputs
		ext_en = 24'hFFFFFF;
		for (int p = 0; p < 4; p++)
		begin
			ext_val = $random(seed);
			v = $random(seed);
			w = $random(seed);
			g = $random(seed);
			g[2:0] = 3'(g[2:0] % wid[p]);
			wr(pdp_pkg::DIRECTION_ADDR[p], v);
			wr(pdp_pkg::LATCH_ADDR[p], w);
			acc(1'h1, 1'h1, g[2:0], g[7], pdp_pkg::LATCH_ADDR[p], 8'h00);
			ex = (sel(ext_val, p) & v) | (w & ~v);
			ex[g[2:0]] = g[7];
			ex = ex & pdp_pkg::PORT_MASK[p];
			wr(pdp_pkg::DIRECTION_ADDR[p], 8'h00);
			settle();
			chk(sel(pin_drv, p), ex);
			rchk(pdp_pkg::LATCH_ADDR[p], ex);
		end
		$display("bit operations done");
		complete_run();
	end
endmodule
